// *** prox_pkg.sv ***
package prox_pkg;

  // Byte offsets of the register map.
  localparam logic [7:0] OFS_ENABLE = 8'h00;
  localparam logic [7:0] OFS_PULSES = 8'h04;
  localparam logic [7:0] OFS_DRIVE = 8'h08;
  localparam logic [7:0] OFS_WAIT = 8'h0c;
  localparam logic [7:0] OFS_LOW_THR = 8'h10;
  localparam logic [7:0] OFS_HIGH_THR = 8'h14;
  localparam logic [7:0] OFS_PERSIST = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1c;
  localparam logic [7:0] OFS_MASK = 8'h20;
  localparam logic [7:0] OFS_DATA_VIS = 8'h24;
  localparam logic [7:0] OFS_DATA_IR = 8'h28;
  localparam logic [7:0] OFS_STATE = 8'h2c;
  localparam logic [7:0] OFS_CONFIG = 8'h30;

  // Bit positions in the enable register.
  localparam int EN_POWER = 0;
  localparam int EN_PROX = 1;
  localparam int EN_WAIT = 2;
  localparam int EN_INT = 3;

  // Bit positions in the status and mask registers.
  localparam int ST_THR = 0;
  localparam int ST_DONE = 1;

  // Bit position of the long-wait flag in the config register.
  localparam int CFG_WLONG = 0;

  // Reset values.
  localparam logic [3:0] RST_ENABLE = 4'h0;
  localparam logic [7:0] RST_PULSES = 8'h01;
  localparam logic [1:0] RST_DRIVE = 2'h0;
  localparam logic [7:0] RST_WAIT = 8'hff;
  localparam logic [15:0] RST_LOW_THR = 16'h0000;
  localparam logic [15:0] RST_HIGH_THR = 16'hffff;
  localparam logic [3:0] RST_PERSIST = 4'h0;
  localparam logic [1:0] RST_MASK = 2'h0;
  localparam logic RST_CONFIG = 1'b0;

  // Drive level codes, strongest first.
  localparam logic [1:0] DRV_100MA = 2'h0;
  localparam logic [1:0] DRV_50MA = 2'h1;
  localparam logic [1:0] DRV_25MA = 2'h2;
  localparam logic [1:0] DRV_12MA5 = 2'h3;

  // Timing, in their own units, and derived cycle counts at 100 MHz.
  localparam int CLK_MHZ = 100;
  localparam int PULSE_PERIOD_NS = 16000;
  localparam int PULSE_ON_NS = 7200;
  localparam int WAIT_STEP_US = 2720;
  localparam int PULSE_PERIOD_CYC = (PULSE_PERIOD_NS * CLK_MHZ) / 1000;
  localparam int PULSE_ON_CYC = (PULSE_ON_NS * CLK_MHZ) / 1000;
  localparam int WAIT_STEP_CYC = WAIT_STEP_US * CLK_MHZ;
  // Smallest whole factor that carries 256 wait steps past eight seconds.
  localparam int WAIT_LONG_MULT = 12;

  typedef enum logic [1:0] {
    ST_SLEEP,
    ST_PULSE,
    ST_CONVERT,
    ST_WAIT
  } sense_state_e;

  // Result pair from the two integrating converters.
  typedef struct packed {
    logic [15:0] vis;
    logic [15:0] ir;
  } conv_result_s;

endpackage

// *** proximity_sense_control.sv ***
`timescale 1ns/1ns
module proximity_sense_control #(
  parameter int WAIT_STEP_CYC = prox_pkg::WAIT_STEP_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic conv_start,
  input wire logic conv_done,
  input wire prox_pkg::conv_result_s conv_result,
  output logic emitter_drive_output,
  output logic emitter_drive_output_oe_n,
  output logic [1:0] emitter_drive_level,
  output logic int_o,
  output logic int_oe_n
);

  typedef struct packed {
    prox_pkg::sense_state_e st;
    logic [3:0] enable;
    logic [7:0] pulses;
    logic [1:0] drive;
    logic [7:0] wtime;
    logic wlong;
    logic [15:0] low_thr;
    logic [15:0] high_thr;
    logic [3:0] persist;
    logic [1:0] status;
    logic [1:0] mask;
    logic [15:0] vis;
    logic [15:0] ir;
    logic [19:0] tick;
    logic [7:0] pcount;
    logic [8:0] steps;
    logic [3:0] wsub;
    logic [3:0] pers_cnt;
    logic done_s1;
    logic done_s2;
    logic done_s3;
    logic ap_wr;
    logic [7:0] ap_addr;
    logic [31:0] rdata;
    logic led;
    logic start;
  } ctrl_s;

  ctrl_s q;
  ctrl_s d;

  logic ap_valid;
  logic done_rise;
  logic out_of_range;
  logic irq;

  assign ap_valid = hsel && hready && htrans[1];
  assign done_rise = q.done_s2 && !q.done_s3;
  assign out_of_range = (conv_result.vis > q.high_thr) ||
                        (conv_result.vis < q.low_thr);
  // The block never stalls the bus, so every transfer is zero-wait.
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = q.rdata;
  assign conv_start = q.start;
  assign emitter_drive_output = 1'b0;
  assign emitter_drive_output_oe_n = !q.led;
  assign emitter_drive_level = q.drive;
  assign irq = q.enable[prox_pkg::EN_INT] && |(q.status & q.mask);
  assign int_o = 1'b0;
  assign int_oe_n = !irq;

  // All next-state logic: bus slave, sequencer, filter and interrupt.
  always_comb begin
    logic thr_evt;
    logic done_evt;
    logic rd_clear;
    logic [3:0] next_pers;
    d = q;
    thr_evt = 1'b0;
    done_evt = 1'b0;
    rd_clear = 1'b0;
    next_pers = q.pers_cnt;
    d.start = 1'b0;
    // The converter flag is asynchronous; the second and third stages detect its rise.
    d.done_s1 = conv_done;
    d.done_s2 = q.done_s1;
    d.done_s3 = q.done_s2;

    // Address phase: latch a write, prepare read data for the data phase.
    d.ap_wr = ap_valid && hwrite;
    d.ap_addr = haddr[7:0];
    if (ap_valid && !hwrite) begin
      unique case (haddr[7:0])
        prox_pkg::OFS_ENABLE: d.rdata = {28'h0000000, q.enable};
        prox_pkg::OFS_PULSES: d.rdata = {24'h000000, q.pulses};
        prox_pkg::OFS_DRIVE: d.rdata = {30'h00000000, q.drive};
        prox_pkg::OFS_WAIT: d.rdata = {24'h000000, q.wtime};
        prox_pkg::OFS_LOW_THR: d.rdata = {16'h0000, q.low_thr};
        prox_pkg::OFS_HIGH_THR: d.rdata = {16'h0000, q.high_thr};
        prox_pkg::OFS_PERSIST: d.rdata = {28'h0000000, q.persist};
        prox_pkg::OFS_STATUS: begin
          d.rdata = {30'h00000000, q.status};
          rd_clear = 1'b1;
        end
        prox_pkg::OFS_MASK: d.rdata = {30'h00000000, q.mask};
        prox_pkg::OFS_DATA_VIS: d.rdata = {16'h0000, q.vis};
        prox_pkg::OFS_DATA_IR: d.rdata = {16'h0000, q.ir};
        prox_pkg::OFS_STATE: d.rdata = {30'h00000000, q.st};
        prox_pkg::OFS_CONFIG: d.rdata = {31'h00000000, q.wlong};
        default: d.rdata = 32'h00000000;
      endcase
    end

    // Data phase of a write.
    if (q.ap_wr) begin
      unique case (q.ap_addr)
        prox_pkg::OFS_ENABLE: d.enable = hwdata[3:0];
        prox_pkg::OFS_PULSES: d.pulses = hwdata[7:0];
        prox_pkg::OFS_DRIVE: d.drive = hwdata[1:0];
        prox_pkg::OFS_WAIT: d.wtime = hwdata[7:0];
        prox_pkg::OFS_LOW_THR: d.low_thr = hwdata[15:0];
        prox_pkg::OFS_HIGH_THR: d.high_thr = hwdata[15:0];
        prox_pkg::OFS_PERSIST: d.persist = hwdata[3:0];
        prox_pkg::OFS_MASK: d.mask = hwdata[1:0];
        prox_pkg::OFS_CONFIG: d.wlong = hwdata[prox_pkg::CFG_WLONG];
        default: ;
      endcase
    end

    // Measurement sequencer.
    unique case (q.st)
      prox_pkg::ST_SLEEP: begin
        d.led = 1'b0;
        if (q.enable[prox_pkg::EN_POWER] &&
            q.enable[prox_pkg::EN_PROX]) begin
          d.st = prox_pkg::ST_PULSE;
          d.tick = 20'h00000;
          d.pcount = 8'h00;
          d.start = 1'b1;
        end
      end
      prox_pkg::ST_PULSE: begin
        // A zero pulse count still converts, just with the emitter dark.
        if (q.pcount == q.pulses) begin
          d.led = 1'b0;
          d.st = prox_pkg::ST_CONVERT;
        end else if (q.tick == 20'(prox_pkg::PULSE_PERIOD_CYC - 1)) begin
          d.tick = 20'h00000;
          d.pcount = q.pcount + 8'h01;
          d.led = 1'b0;
        end else begin
          d.tick = q.tick + 20'h00001;
          d.led = (q.tick < 20'(prox_pkg::PULSE_ON_CYC));
        end
      end
      prox_pkg::ST_CONVERT: begin
        if (done_rise) begin
          d.vis = conv_result.vis;
          d.ir = conv_result.ir;
          done_evt = 1'b1;
          if (out_of_range) begin
            if (q.pers_cnt != 4'hf) begin
              next_pers = q.pers_cnt + 4'h1;
            end
            thr_evt = (next_pers >= q.persist);
          end else begin
            next_pers = 4'h0;
          end
          d.pers_cnt = next_pers;
          d.tick = 20'h00000;
          d.steps = 9'h000;
          d.wsub = 4'h0;
          d.st = q.enable[prox_pkg::EN_WAIT] ? prox_pkg::ST_WAIT :
                 prox_pkg::ST_SLEEP;
        end
      end
      prox_pkg::ST_WAIT: begin
        // Wait length is 256 minus the register value, in whole steps.
        // Without long mode the longest wait falls well short of eight
        // seconds, so long mode repeats each step; wsub counts it 12 times.
        if (q.tick == 20'(WAIT_STEP_CYC - 1)) begin
          d.tick = 20'h00000;
          if (q.wlong &&
              q.wsub != 4'(prox_pkg::WAIT_LONG_MULT - 1)) begin
            d.wsub = q.wsub + 4'h1;
          end else begin
            d.wsub = 4'h0;
            d.steps = q.steps + 9'h001;
            if (q.steps + 9'h001 == 9'h100 - {1'b0, q.wtime}) begin
              d.st = prox_pkg::ST_SLEEP;
            end
          end
        end else begin
          d.tick = q.tick + 20'h00001;
        end
      end
    endcase

    // Clearing power-on sends the sequencer to sleep at once.
    if (!q.enable[prox_pkg::EN_POWER]) begin
      d.st = prox_pkg::ST_SLEEP;
      d.led = 1'b0;
    end

    // A status read clears, but an event in the same cycle wins.
    if (rd_clear) begin
      d.status = 2'h0;
    end
    if (thr_evt) begin
      d.status[prox_pkg::ST_THR] = 1'b1;
    end
    if (done_evt) begin
      d.status[prox_pkg::ST_DONE] = 1'b1;
    end
  end

  // State register; reset puts everything asleep and quiet.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
      q.st <= prox_pkg::ST_SLEEP;
      q.enable <= prox_pkg::RST_ENABLE;
      q.pulses <= prox_pkg::RST_PULSES;
      q.drive <= prox_pkg::RST_DRIVE;
      q.wtime <= prox_pkg::RST_WAIT;
      q.wlong <= prox_pkg::RST_CONFIG;
      q.low_thr <= prox_pkg::RST_LOW_THR;
      q.high_thr <= prox_pkg::RST_HIGH_THR;
      q.persist <= prox_pkg::RST_PERSIST;
      q.mask <= prox_pkg::RST_MASK;
    end else begin
      q <= d;
    end
  end

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence pulse_edge_s;
    q.st == prox_pkg::ST_PULSE && q.tick == 20'h00000 &&
      q.pcount != q.pulses;
  endsequence

  AST_DRIVE_LEVEL: assert property (emitter_drive_level == q.drive)
    else $error("Drive level does not follow its register.");
  AST_PULSE_COUNT: assert property (
    q.st == prox_pkg::ST_PULSE && q.pcount == q.pulses |=>
      q.st == prox_pkg::ST_CONVERT || q.st == prox_pkg::ST_SLEEP)
    else $error("Sequencer overran the pulse count.");
  AST_PULSE_PERIOD: assert property (
    q.st == prox_pkg::ST_PULSE && q.tick < 20'(prox_pkg::PULSE_ON_CYC) &&
      q.tick > 20'h00000 && q.pcount != q.pulses &&
      q.enable[prox_pkg::EN_POWER] |-> !emitter_drive_output_oe_n)
    else $error("Emitter not on during the on part of a pulse.");
  AST_PULSE_OFF: assert property (
    q.tick > 20'(prox_pkg::PULSE_ON_CYC) |-> emitter_drive_output_oe_n)
    else $error("Emitter on past its on time.");
  AST_DATA_COPY: assert property (
    q.st == prox_pkg::ST_CONVERT && done_rise |=>
      q.vis == $past(conv_result.vis) && q.ir == $past(conv_result.ir))
    else $error("Result not copied at conversion end.");
  AST_INT_HOLD: assert property (
    irq && !(ap_valid && !hwrite && haddr[7:0] == prox_pkg::OFS_STATUS) &&
      $stable(q.mask) && q.enable[prox_pkg::EN_INT] &&
      !q.ap_wr |=> irq)
    else $error("Interrupt dropped without a clear.");
  AST_INT_PIN: assert property (int_oe_n == !irq)
    else $error("Interrupt pin disagrees with status and mask.");
  AST_THR_EVENT: assert property (
    q.st == prox_pkg::ST_CONVERT && done_rise && out_of_range &&
      q.persist == 4'h0 |=> q.status[prox_pkg::ST_THR])
    else $error("Out-of-range result did not raise the event.");
  AST_IN_RANGE: assert property (
    q.st == prox_pkg::ST_CONVERT && done_rise && !out_of_range |=>
      q.pers_cnt == 4'h0)
    else $error("Persistence count not reset by in-range result.");
  AST_SLEEP: assert property (
    !q.enable[prox_pkg::EN_POWER] |=> q.st == prox_pkg::ST_SLEEP)
    else $error("Sequencer active while powered down.");
  AST_PULSE_START: assert property (pulse_edge_s ##1 q.tick == 20'h00001
    |-> !emitter_drive_output_oe_n)
    else $error("Pulse did not start the emitter.");

  // Last cycle of one wait step.
  sequence wait_tick_s;
    q.st == prox_pkg::ST_WAIT && q.tick == 20'(WAIT_STEP_CYC - 1);
  endsequence

  // A completed conversion as the sequencer sees it.
  sequence conv_end_s;
    q.st == prox_pkg::ST_CONVERT && done_rise;
  endsequence

  // Address phase of a status read.
  sequence status_read_s;
    ap_valid && !hwrite && haddr[7:0] == prox_pkg::OFS_STATUS;
  endsequence

  // Wait timer, threshold, data hold, clear and wake-up checks.
  AST_WAIT_LONG: assert property (
    wait_tick_s ##0 (q.wlong && q.enable[prox_pkg::EN_POWER] &&
      q.wsub != 4'(prox_pkg::WAIT_LONG_MULT - 1)) |=>
      q.st == prox_pkg::ST_WAIT && $stable(q.steps))
    else $error("Long wait left a step early.");
  AST_WAIT_STEP: assert property (
    wait_tick_s ##0 !q.wlong |=> q.steps == $past(q.steps) + 9'h001)
    else $error("Wait step not counted.");
  AST_LOW_THR: assert property (
    conv_end_s ##0 (conv_result.vis < q.low_thr) |=> q.pers_cnt != 4'h0)
    else $error("Result below the lower threshold not counted.");
  AST_DATA_HOLD: assert property (
    !(q.st == prox_pkg::ST_CONVERT && done_rise) |=>
      $stable(q.vis) && $stable(q.ir))
    else $error("Result registers changed without a conversion end.");
  AST_STATUS_CLEAR: assert property (
    status_read_s ##0 !(q.st == prox_pkg::ST_CONVERT && done_rise) |=>
      q.status == 2'h0)
    else $error("Status read did not clear the flags.");
  AST_WAKE: assert property (
    q.st == prox_pkg::ST_SLEEP && q.enable[prox_pkg::EN_POWER] &&
      q.enable[prox_pkg::EN_PROX] |=>
      q.st == prox_pkg::ST_PULSE && conv_start)
    else $error("Enabled sequencer did not leave sleep.");

endmodule

// *** conv_model.sv ***
`timescale 1ns/1ns
// Stand-in for the two external integrating converters.
module conv_model #(
  parameter int DELAY = 4000
) (
  input wire logic hclk,
  input wire logic conv_start,
  input wire prox_pkg::conv_result_s next_res,
  output logic conv_done,
  output prox_pkg::conv_result_s conv_result
);
  int cnt = 0;

  // The answer comes late enough to follow the emitter burst.
  // Both channels are presented together, a cycle before done rises.
  // Outside that window the inverse is shown, so a stale latch is caught.
  always @(posedge hclk) begin
    if (conv_start) begin
      cnt <= DELAY;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
    conv_done <= (cnt > 0 && cnt <= 8);
    conv_result <= (cnt > 0 && cnt <= 9) ? next_res : ~next_res;
  end
endmodule

// *** testbench.sv ***
`timescale 1ns/1ns
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin mismatches++; \
  $display("[FAIL] %0t got %h want %h", $time, a, e); end end
module testbench;
  typedef struct packed {logic [7:0] a; logic [31:0] e;} row_s;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = '0;
  logic [31:0] hwdata = '0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hrdata, rd;
  logic hreadyout, hresp, conv_start, conv_done, eo, eo_n, io, int_oe_n;
  logic [1:0] lvl;
  prox_pkg::conv_result_s res;
  prox_pkg::conv_result_s nres = {16'd200, 16'h1234};
  int mismatches = 0;
  int total_checks = 0;
  int on_cnt = 0;
  int n;
  // Reset values, plus one unmapped address that must read zero.
  row_s rows[11] = '{'{8'h00, 32'h0}, '{8'h04, 32'h1}, '{8'h08, 32'h0},
    '{8'h0c, 32'hff}, '{8'h10, 32'h0}, '{8'h14, 32'hffff},
    '{8'h18, 32'h0}, '{8'h20, 32'h0}, '{8'h2c, 32'h0}, '{8'h30, 32'h0},
    '{8'h40, 32'h0}};

  // Free-running bus clock.
  always #5 hclk = ~hclk;

  proximity_sense_control #(.WAIT_STEP_CYC(20)) dut_u (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .conv_start(conv_start), .conv_done(conv_done), .conv_result(res),
    .emitter_drive_output(eo), .emitter_drive_output_oe_n(eo_n),
    .emitter_drive_level(lvl), .int_o(io), .int_oe_n(int_oe_n));

  conv_model #(.DELAY(4000)) conv_u (.hclk(hclk), .conv_start(conv_start),
    .next_res(nres), .conv_done(conv_done), .conv_result(res));

  // Emitter on-time of one measurement, restarted by each conv_start.
  always @(posedge hclk) begin
    if (conv_start) begin
      on_cnt <= 0;
    end else if (eo_n === 1'b0) begin
      on_cnt <= on_cnt + 1;
    end
  end

  task automatic finish_test;
    if (mismatches == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Bounded wait for a level; running out counts as a failure.
  task automatic wt(ref logic s, input int lim);
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (s !== 1'b1 && n < lim);
    if (n >= lim) begin
      mismatches++;
      finish_test();
    end
  endtask

  // One single AHB-Lite word transfer; read data lands in rd.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    wt(hreadyout, 50);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wt(hreadyout, 50);
    rd = hrdata;
  endtask

  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    #1;
    `CHK(int_oe_n, 1'b1)
    `CHK(eo_n, 1'b1)
    `CHK(hresp, 1'b0)
    `CHK(eo, 1'b0)
    `CHK(io, 1'b0)
    foreach (rows[i]) begin
      bus(1'b0, rows[i].a, 32'h0);
      `CHK(rd, rows[i].e)
    end
    // Every drive code must reach the level pins.
    for (int c = 0; c < 4; c++) begin
      bus(1'b1, 8'h08, 32'(c));
      repeat (2) @(posedge hclk);
      #1;
      `CHK(lvl, 2'(c))
    end
    bus(1'b1, 8'h04, 32'h2);
    bus(1'b1, 8'h0c, 32'hfe);
    bus(1'b1, 8'h14, 32'd100);
    bus(1'b1, 8'h18, 32'h2);
    bus(1'b1, 8'h20, 32'h1);
    bus(1'b1, 8'h00, 32'hf);
    wt(conv_done, 9000);
    `CHK(on_cnt, 1440)
    repeat (12) @(posedge hclk);
    `CHK(int_oe_n, 1'b1)
    bus(1'b0, 8'h1c, 32'h0);
    `CHK(rd, 32'h2)
    wt(conv_done, 9000);
    repeat (12) @(posedge hclk);
    bus(1'b0, 8'h2c, 32'h0);
    `CHK(rd, 32'h3)
    `CHK(int_oe_n, 1'b0)
    bus(1'b0, 8'h24, 32'h0);
    `CHK(rd, 32'd200)
    bus(1'b0, 8'h28, 32'h0);
    `CHK(rd, 32'h1234)
    `CHK(int_oe_n, 1'b0)
    bus(1'b0, 8'h1c, 32'h0);
    `CHK(rd, 32'h3)
    @(posedge hclk);
    #1;
    `CHK(int_oe_n, 1'b1)
    bus(1'b1, 8'h00, 32'h0);
    bus(1'b0, 8'h2c, 32'h0);
    `CHK(rd, 32'h0)
    `CHK(eo_n, 1'b1)
    // Below the lower threshold with no persistence, then a long wait.
    bus(1'b1, 8'h10, 32'd60);
    bus(1'b1, 8'h18, 32'h0);
    bus(1'b1, 8'h30, 32'h1);
    nres <= {16'd50, 16'h00ab};
    bus(1'b1, 8'h00, 32'hf);
    wt(conv_done, 9000);
    repeat (100) @(posedge hclk);
    bus(1'b0, 8'h2c, 32'h0);
    `CHK(rd, 32'h3)
    `CHK(int_oe_n, 1'b0)
    bus(1'b0, 8'h1c, 32'h0);
    `CHK(rd, 32'h3)
    // An in-range result resets the run and raises no threshold event.
    nres <= {16'd80, 16'h0055};
    wt(conv_done, 9000);
    repeat (12) @(posedge hclk);
    `CHK(int_oe_n, 1'b1)
    bus(1'b0, 8'h1c, 32'h0);
    `CHK(rd, 32'h2)
    bus(1'b0, 8'h24, 32'h0);
    `CHK(rd, 32'd80)
    bus(1'b1, 8'h00, 32'h0);
    finish_test();
  end
endmodule
